// >>> hdl/twmsp_pkg.sv
// Package for the two-wire master/slave port: register map, field
// positions, reset values, bit-rate counts, states and the bus carrier.
// Assumes a 25 MHz core clock and a classic Wishbone master outside.
package twmsp_pkg;

  // Core clock and bit rates
  localparam int CLK_KHZ = 25000;
  localparam int RATE_STD_KBPS = 100;
  localparam int RATE_FAST_KBPS = 400;
  localparam int RATE_SLOW_KBPS = 50;
  // Quarter bit periods in core cycles, rounded up so no rate is exceeded
  localparam logic [9:0] QTR_STD =
    10'((CLK_KHZ + 4 * RATE_STD_KBPS - 1) / (4 * RATE_STD_KBPS));
  localparam logic [9:0] QTR_FAST =
    10'((CLK_KHZ + 4 * RATE_FAST_KBPS - 1) / (4 * RATE_FAST_KBPS));
  localparam logic [9:0] QTR_SLOW =
    10'((CLK_KHZ + 4 * RATE_SLOW_KBPS - 1) / (4 * RATE_SLOW_KBPS));
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FLAG4 = 6'h17;
  localparam logic [5:0] IDX_MASK4 = 6'h1E;
  localparam logic [5:0] IDX_CTL1 = 6'h30;
  localparam logic [5:0] IDX_CTL2 = 6'h31;
  localparam logic [5:0] IDX_TSA = 6'h32;
  localparam logic [5:0] IDX_DB = 6'h33;
  localparam logic [5:0] IDX_OWN_LO = 6'h34;
  localparam logic [5:0] IDX_OWN_HI = 6'h35;

  // twowire_control_one fields
  localparam int C1_GO = 7;
  localparam int C1_MS = 6;
  localparam int C1_ISS = 5;
  localparam int C1_STOP = 4;
  localparam int C1_ADDRESS_REG_EMPTY_FLAG = 3;
  localparam int C1_ACK = 2;
  localparam int C1_FULL = 1;
  localparam int C1_EMPTY = 0;
  // twowire_control_two fields
  localparam int C2_BUF = 7;
  localparam int C2_GCE = 6;
  localparam int C2_BUSY = 4;
  localparam int C2_TS1 = 3;
  localparam int C2_TS0 = 2;
  localparam int C2_EN = 0;
  // peripheral_flag_four / peripheral_irq_mask_four fields
  localparam int F_STOP = 2;
  localparam int F_RX = 1;
  localparam int F_TX = 0;

  // Reset values
  localparam logic [7:0] CTL1_RST = 8'h09;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [1:0] OWN_HI_RST = 2'h0;

  // First-byte prefix that marks a ten-bit address
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01, M_START = 5'h02, M_XFER = 5'h04,
    M_HOLD = 5'h08, M_STOP = 5'h10
  } twmsp_mstate_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_RX = 6'h02, S_ACK = 6'h04,
    S_HOLD = 6'h08, S_TX = 6'h10, S_TXACK = 6'h20
  } twmsp_sstate_t;

  // Wishbone request as one carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } twmsp_wb_req_t;

endpackage

// >>> hdl/twmsp_port.sv
// Two-wire serial bus controller, master or slave, 7/10-bit addressing.
// Assumes a classic Wishbone master and open-drain pads resolved outside.
`timescale 1ns/10ps

module twmsp_port
  import twmsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire twmsp_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);

  // Pin synchronisers and glitch filter
  logic [2:0] scl_sync_reg, scl_sync_next, sda_sync_reg, sda_sync_next;
  logic scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
  logic scl_q_reg, sda_q_reg;

  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_i};
    sda_sync_next = {sda_sync_reg[1:0], sda_i};
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2]
                                                       : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2]
                                                       : sda_f_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      scl_q_reg <= scl_f_reg;
      sda_q_reg <= sda_f_reg;
    end
  end

  // Line events seen by every mode
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_f_reg & ~scl_q_reg;
  assign scl_fall = ~scl_f_reg & scl_q_reg;
  assign start_det = scl_f_reg & scl_q_reg & sda_q_reg & ~sda_f_reg;
  assign stop_det = scl_f_reg & scl_q_reg & ~sda_q_reg & sda_f_reg;

  // Quarter-bit tick divider
  logic [7:0] ctl1_reg, ctl1_next, ctl2_reg, ctl2_next;
  logic [9:0] qcnt_reg, qcnt_next, qmax;
  logic tick_reg, tick_next;

  always_comb begin
    unique case ({ctl2_reg[C2_TS1], ctl2_reg[C2_TS0]})
      2'b00: qmax = QTR_STD;
      2'b01: qmax = QTR_FAST;
      default: qmax = QTR_SLOW;
    endcase
    if (ctl1_reg[C1_ISS]) begin
      qmax = {qmax[8:0], 1'b0};
    end
    tick_next = 1'b0;
    qcnt_next = qcnt_reg + 10'h001;
    if (qcnt_reg >= qmax - 10'h001) begin
      qcnt_next = 10'h000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qcnt_reg <= 10'h000;
      tick_reg <= 1'b0;
    end else begin
      qcnt_reg <= qcnt_next;
      tick_reg <= tick_next;
    end
  end

  // Core registers, bus slave, master and slave engines
  logic [7:0] tsa_reg, tsa_next, db_reg, db_next, own_lo_reg, own_lo_next;
  logic [1:0] own_hi_reg, own_hi_next;
  logic [2:0] flag_reg, flag_next, mask_reg, mask_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  twmsp_mstate_t m_state_reg, m_state_next;
  twmsp_sstate_t s_state_reg, s_state_next;
  logic [1:0] phase_reg, phase_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic m_read_reg, m_read_next, m_addr_reg, m_addr_next;
  logic busy_reg, busy_next;
  logic s_adr_reg, s_adr_next, s_tx_reg, s_tx_next;
  logic s_ten_reg, s_ten_next, s_first_reg, s_first_next;
  logic s_evt_reg, s_evt_next;
  logic scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;
  logic pin_lo_reg;

  logic hit, wr, en, ms, adv, rd, shifting, ten, ok;
  logic [7:0] rdat, wdat;
  logic [5:0] idx;

  assign en = ctl2_reg[C2_EN];
  assign ms = ctl1_reg[C1_MS];
  assign rd = m_read_reg & ~m_addr_reg;
  assign adv = tick_reg & ((phase_reg != 2'h2) | scl_f_reg);
  assign shifting = (m_state_reg == M_START) | (m_state_reg == M_XFER) |
                    (m_state_reg == M_STOP) | (s_state_reg == S_RX) |
                    (s_state_reg == S_TX) | (s_state_reg == S_TXACK);
  assign idx = wb_req_i.adr[7:2];
  assign wdat = wb_req_i.dat[7:0];
  assign hit = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
  assign wr = hit & wb_req_i.we & wb_req_i.sel[0];

  always_comb begin
    ctl1_next = ctl1_reg;
    ctl2_next = ctl2_reg;
    tsa_next = tsa_reg;
    db_next = db_reg;
    own_lo_next = own_lo_reg;
    own_hi_next = own_hi_reg;
    flag_next = flag_reg;
    mask_next = mask_reg;
    m_state_next = m_state_reg;
    s_state_next = s_state_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    m_read_next = m_read_reg;
    m_addr_next = m_addr_reg;
    busy_next = busy_reg;
    s_adr_next = s_adr_reg;
    s_tx_next = s_tx_reg;
    s_ten_next = s_ten_reg;
    s_first_next = s_first_reg;
    s_evt_next = s_evt_reg;
    scl_oe_n_next = scl_oe_n_reg;
    sda_oe_n_next = sda_oe_n_reg;
    ten = 1'b0;
    ok = 1'b0;
    // Bus slave: one-cycle answer, unmapped reads zero
    ack_next = hit;
    unique case (idx)
      IDX_FLAG4: rdat = {5'h00, flag_reg};
      IDX_MASK4: rdat = {5'h00, mask_reg};
      IDX_CTL1: rdat = ctl1_reg;
      IDX_CTL2: rdat = ctl2_reg | ({7'h00, shifting} << C2_BUF)
                                | ({7'h00, busy_reg} << C2_BUSY);
      IDX_TSA: rdat = tsa_reg;
      IDX_DB: rdat = db_reg;
      IDX_OWN_LO: rdat = own_lo_reg;
      IDX_OWN_HI: rdat = {6'h00, own_hi_reg};
      default: rdat = 8'h00;
    endcase
    dat_next = hit ? {24'h000000, rdat} : dat_reg;
    if (hit & ~wb_req_i.we & (idx == IDX_DB)) begin
      ctl1_next[C1_FULL] = 1'b0;
    end
    if (wr) begin
      unique case (idx)
        IDX_FLAG4: flag_next = flag_reg & wdat[2:0];
        IDX_MASK4: mask_next = wdat[2:0];
        IDX_CTL1: ctl1_next[7:4] = wdat[7:4];
        IDX_CTL2: begin
          ctl2_next[C2_GCE] = wdat[C2_GCE];
          ctl2_next[C2_TS1] = wdat[C2_TS1];
          ctl2_next[C2_TS0] = wdat[C2_TS0];
          ctl2_next[C2_EN] = wdat[C2_EN];
        end
        IDX_TSA: begin
          tsa_next = wdat;
          ctl1_next[C1_ADDRESS_REG_EMPTY_FLAG] = 1'b0;
        end
        IDX_DB: begin
          db_next = wdat;
          ctl1_next[C1_EMPTY] = 1'b0;
        end
        IDX_OWN_LO: own_lo_next = wdat;
        IDX_OWN_HI: own_hi_next = wdat[1:0];
        default: ;
      endcase
    end
    // Bus busy tracking in every mode
    if (start_det) begin
      busy_next = 1'b1;
    end else if (stop_det) begin
      busy_next = 1'b0;
    end
    if (~en) begin
      m_state_next = M_IDLE;
      s_state_next = S_IDLE;
      s_adr_next = 1'b0;
      scl_oe_n_next = 1'b1;
      sda_oe_n_next = 1'b1;
    end else if (ms) begin
      // Master engine, four quarter phases per bit
      if (adv) begin
        phase_next = phase_reg + 2'h1;
      end
      unique case (m_state_reg)
        M_IDLE: begin
          phase_next = 2'h0;
          if (ctl1_reg[C1_GO] & ~busy_reg) begin
            m_state_next = M_START;
          end
        end
        M_START: if (adv) begin
          unique case (phase_reg)
            2'h0: sda_oe_n_next = 1'b1;
            2'h1: scl_oe_n_next = 1'b1;
            2'h2: sda_oe_n_next = 1'b0;
            default: begin
              scl_oe_n_next = 1'b0;
              m_state_next = M_XFER;
              shift_next = tsa_reg;
              cnt_next = 4'h0;
              m_addr_next = 1'b1;
              ctl1_next[C1_ADDRESS_REG_EMPTY_FLAG] = 1'b1;
            end
          endcase
        end
        M_XFER: if (adv) begin
          unique case (phase_reg)
            2'h0: begin
              if (cnt_reg < BITS_PER_BYTE) begin
                sda_oe_n_next = rd | shift_reg[7];
              end else begin
                sda_oe_n_next = rd ? ctl1_reg[C1_STOP] : 1'b1;
              end
            end
            2'h1: scl_oe_n_next = 1'b1;
            2'h2: begin
              if (cnt_reg < BITS_PER_BYTE) begin
                shift_next = {shift_reg[6:0], sda_f_reg};
              end else if (~rd) begin
                ctl1_next[C1_ACK] = ~sda_f_reg;
              end
            end
            default: begin
              scl_oe_n_next = 1'b0;
              cnt_next = cnt_reg + 4'h1;
              if (cnt_reg == BITS_PER_BYTE) begin
                ctl1_next[C1_GO] = 1'b0;
                if (rd) begin
                  db_next = shift_reg;
                  ctl1_next[C1_FULL] = 1'b1;
                  flag_next[F_RX] = 1'b1;
                end else begin
                  flag_next[F_TX] = 1'b1;
                  ctl1_next[C1_EMPTY] = ~m_addr_reg;
                end
                if (m_addr_reg) begin
                  m_read_next = tsa_reg[0];
                end
                m_addr_next = 1'b0;
                m_state_next = ctl1_reg[C1_STOP] ? M_STOP : M_HOLD;
              end
            end
          endcase
        end
        M_HOLD: begin
          phase_next = 2'h0;
          if (ctl1_reg[C1_GO] & ~ctl1_reg[C1_ADDRESS_REG_EMPTY_FLAG]) begin
            m_state_next = M_START;
          end else if (ctl1_reg[C1_GO]) begin
            m_state_next = M_XFER;
            shift_next = db_reg;
            cnt_next = 4'h0;
          end else if (ctl1_reg[C1_STOP]) begin
            m_state_next = M_STOP;
          end
        end
        default: if (adv) begin
          unique case (phase_reg)
            2'h0: sda_oe_n_next = 1'b0;
            2'h1: scl_oe_n_next = 1'b1;
            2'h2: sda_oe_n_next = 1'b1;
            default: begin
              m_state_next = M_IDLE;
              ctl1_next[C1_STOP] = 1'b0;
              flag_next[F_STOP] = 1'b1;
            end
          endcase
        end
      endcase
    end else begin
      // Slave engine, driven by filtered clock edges
      if (stop_det) begin
        s_state_next = S_IDLE;
        if (s_adr_reg) begin
          flag_next[F_STOP] = 1'b1;
        end
        s_adr_next = 1'b0;
        scl_oe_n_next = 1'b1;
        sda_oe_n_next = 1'b1;
      end else if (start_det) begin
        s_state_next = S_RX;
        cnt_next = 4'h0;
        s_first_next = 1'b1;
        scl_oe_n_next = 1'b1;
        sda_oe_n_next = 1'b1;
      end else begin
        unique case (s_state_reg)
          S_IDLE: ;
          S_RX: begin
            if (scl_rise) begin
              shift_next = {shift_reg[6:0], sda_f_reg};
              cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall & (cnt_reg == BITS_PER_BYTE)) begin
              ten = shift_reg[7:3] == TEN_BIT_PREFIX;
              s_evt_next = 1'b1;
              s_ten_next = 1'b0;
              s_first_next = 1'b0;
              if (s_first_reg & ten & ~shift_reg[0]) begin
                ok = shift_reg[2:1] == own_hi_reg;
                s_ten_next = ok;
                s_evt_next = 1'b0;
                s_adr_next = 1'b0;
              end else if (s_first_reg & ten) begin
                ok = s_adr_reg & (shift_reg[2:1] == own_hi_reg);
                s_adr_next = ok;
                s_tx_next = 1'b1;
              end else if (s_first_reg) begin
                ok = (shift_reg[7:1] == own_lo_reg[6:0]) |
                     (ctl2_reg[C2_GCE] & (shift_reg == 8'h00));
                s_adr_next = ok;
                s_tx_next = shift_reg[0];
              end else if (s_ten_reg) begin
                ok = shift_reg == own_lo_reg;
                s_adr_next = ok;
                s_tx_next = 1'b0;
              end else begin
                ok = s_adr_reg;
              end
              if (ok) begin
                sda_oe_n_next = 1'b0;
                s_state_next = S_ACK;
                if (~s_ten_next & ~s_tx_next) begin
                  db_next = shift_reg;
                  ctl1_next[C1_FULL] = 1'b1;
                end
              end else begin
                s_state_next = S_IDLE;
              end
            end
          end
          S_ACK: if (scl_fall) begin
            sda_oe_n_next = 1'b1;
            cnt_next = 4'h0;
            if (s_evt_reg) begin
              ctl1_next[C1_GO] = 1'b1;
              flag_next[s_tx_reg ? F_TX : F_RX] = 1'b1;
              scl_oe_n_next = 1'b0;
              s_state_next = S_HOLD;
            end else begin
              s_state_next = S_RX;
            end
          end
          S_HOLD: if (~ctl1_reg[C1_GO]) begin
            scl_oe_n_next = 1'b1;
            cnt_next = 4'h0;
            if (s_tx_reg) begin
              shift_next = db_reg;
              sda_oe_n_next = db_reg[7];
              s_state_next = S_TX;
            end else begin
              s_state_next = S_RX;
            end
          end
          S_TX: if (scl_fall) begin
            cnt_next = cnt_reg + 4'h1;
            shift_next = {shift_reg[6:0], 1'b0};
            sda_oe_n_next = (cnt_reg == 4'h7) | shift_reg[6];
            if (cnt_reg == 4'h7) begin
              s_state_next = S_TXACK;
            end
          end
          default: begin
            if (scl_rise) begin
              s_evt_next = ~sda_f_reg;
            end else if (scl_fall) begin
              if (s_evt_reg) begin
                ctl1_next[C1_GO] = 1'b1;
                flag_next[F_TX] = 1'b1;
                scl_oe_n_next = 1'b0;
                s_state_next = S_HOLD;
              end else begin
                s_state_next = S_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl1_reg <= CTL1_RST;
      ctl2_reg <= CTL2_RST;
      tsa_reg <= BYTE_RST;
      db_reg <= BYTE_RST;
      own_lo_reg <= BYTE_RST;
      own_hi_reg <= OWN_HI_RST;
      flag_reg <= FLAG_RST;
      mask_reg <= FLAG_RST;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      m_state_reg <= M_IDLE;
      s_state_reg <= S_IDLE;
      phase_reg <= 2'h0;
      cnt_reg <= 4'h0;
      shift_reg <= BYTE_RST;
      m_read_reg <= 1'b0;
      m_addr_reg <= 1'b0;
      busy_reg <= 1'b0;
      s_adr_reg <= 1'b0;
      s_tx_reg <= 1'b0;
      s_ten_reg <= 1'b0;
      s_first_reg <= 1'b0;
      s_evt_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      pin_lo_reg <= 1'b0;
    end else begin
      ctl1_reg <= ctl1_next;
      ctl2_reg <= ctl2_next;
      tsa_reg <= tsa_next;
      db_reg <= db_next;
      own_lo_reg <= own_lo_next;
      own_hi_reg <= own_hi_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      m_state_reg <= m_state_next;
      s_state_reg <= s_state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      m_read_reg <= m_read_next;
      m_addr_reg <= m_addr_next;
      busy_reg <= busy_next;
      s_adr_reg <= s_adr_next;
      s_tx_reg <= s_tx_next;
      s_ten_reg <= s_ten_next;
      s_first_reg <= s_first_next;
      s_evt_reg <= s_evt_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
      pin_lo_reg <= 1'b0;
    end
  end

  // Outputs straight from flops; pads only ever pull low
  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign scl_o = pin_lo_reg;
  assign sda_o = pin_lo_reg;
  assign scl_oe_n_o = scl_oe_n_reg;
  assign sda_oe_n_o = sda_oe_n_reg;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> ~wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (hit |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_pads_low: assert property (~scl_o & ~sda_o)
    else $error("pad drives high");
  a_master_sda_low: assert property (
    (m_state_reg == M_XFER) && $changed(sda_oe_n_o) |-> $past(~scl_oe_n_o))
    else $error("master data changed while clock released");
  a_start_order: assert property (
    (m_state_reg == M_START) && adv && (phase_reg == 2'h2)
    |=> ~sda_oe_n_o && scl_oe_n_o)
    else $error("start not made with clock high");
  a_stop_order: assert property (
    (m_state_reg == M_STOP) && adv && (phase_reg == 2'h2)
    |=> sda_oe_n_o && scl_oe_n_o ##[1:300] flag_reg[F_STOP])
    else $error("stop not made or not flagged");
  a_nack_last: assert property (
    (m_state_reg == M_XFER) && adv && (phase_reg == 2'h0) && rd &&
    (cnt_reg == BITS_PER_BYTE) && ctl1_reg[C1_STOP] |=> sda_oe_n_o)
    else $error("last read byte not nacked");
  a_strobe_clear: assert property (
    (m_state_reg == M_XFER) && adv && (phase_reg == 2'h3) &&
    (cnt_reg == BITS_PER_BYTE) |=> ~ctl1_reg[C1_GO] &&
    (flag_reg[F_TX] || flag_reg[F_RX]))
    else $error("byte end did not clear strobe or set flag");
  a_slave_stretch: assert property (
    (s_state_reg == S_HOLD) && $past(s_state_reg == S_HOLD)
    |-> ~scl_oe_n_o && ctl1_reg[C1_GO])
    else $error("slave not stretching while pending");
  a_slave_stop_flag: assert property (
    ~ms && en && s_adr_reg && stop_det |=> flag_reg[F_STOP] && ~s_adr_reg)
    else $error("stop flag missing after addressed stop");
  a_busy_track: assert property (start_det |=> busy_reg)
    else $error("bus busy not set on start");

  c_master_write: cover property ((m_state_reg == M_XFER) && ~rd
    ##[1:1000] (m_state_reg == M_HOLD));
  c_master_read: cover property ((m_state_reg == M_XFER) && rd
    ##[1:1000] flag_reg[F_RX]);
  c_slave_hit: cover property (~ms && s_adr_reg ##1 s_state_reg == S_HOLD);
  c_slave_tx: cover property (s_state_reg == S_TX);

endmodule // twmsp_port

// >>> bench/twmsp_slave_model.sv
// Two-wire slave model: acks and collects every byte, may stretch.
// Assumes pull-ups and wired-AND resolution done by the bench.
`timescale 1ns/10ps
module twmsp_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic slow_i,
  output logic scl_oe_n_o,
  output logic sda_oe_n_o
);
  logic [7:0] sh;
  int n = 0;
  int stops = 0;
  logic [7:0] got[$];
  // Both lines released at start, only pulled low later
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // Start and stop detection
  always @(negedge sda_i) if (scl_i) n = 0;
  always @(posedge sda_i) if (scl_i) stops++;
  // Data taken while the clock is high
  always @(posedge scl_i) begin
    if (n < 8) sh = {sh[6:0], sda_i};
    n++;
  end
  // Ack after eight bits, with optional clock stretch
  always @(negedge scl_i) begin
    if (n == 8) begin
      got.push_back(sh);
      sda_oe_n_o = 1'b0;
      if (slow_i) begin
        scl_oe_n_o = 1'b0;
        #3000 scl_oe_n_o = 1'b1;
      end
    end else if (n == 9) begin
      sda_oe_n_o = 1'b1;
      n = 0;
    end
  end
endmodule // twmsp_slave_model

// >>> bench/twmsp_port_tb_top.sv
// Testbench for the two-wire port in master mode against a slave model.
// Assumes the register map and rate codes of twmsp_pkg.
`timescale 1ns/10ps
module twmsp_port_tb_top import twmsp_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow = 1'b0;
  twmsp_wb_req_t req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, m_scl, m_sda;
  wire logic scl = scl_oe_n_o & m_scl;
  wire logic sda = sda_oe_n_o & m_sda;
  int err_total = 0, samples_checked = 0, seed = 32'h236DCD88;
  int stops0 = 0;
  logic [7:0] q;
  logic [7:0] bq[$];
  realtime t_last = 0;
  initial forever #20 clk_i = ~clk_i;
  twmsp_port i_twmsp_port (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o));
  twmsp_slave_model i_twmsp_slave_model (.scl_i(scl), .sda_i(sda),
    .slow_i(slow), .scl_oe_n_o(m_scl), .sda_oe_n_o(m_sda));
  task automatic chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [5:0] ix, input logic [7:0] d);
    int t = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, {ix, 2'b00}, 4'hF, {24'h0, d}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 99);
    chk("wb_ack", 8'h01, {7'h0, wb_ack_o});
    q = wb_dat_o[7:0];
    req <= '0;
  endtask
  // Wait for a flag, then clear the flags
  task automatic poll(input int b);
    int t = 0;
    do wb(1'b0, IDX_FLAG4, 8'h00); while (q[b] !== 1'b1 && ++t < 2000);
    chk("flag", 8'h01, {7'h0, q[b]});
    wb(1'b1, IDX_FLAG4, 8'h00);
  endtask
  // Master write of bq: first byte from address reg, rest from buffer
  task automatic xfer(input logic [7:0] rate);
    wb(1'b1, IDX_CTL2, rate);
    wb(1'b1, IDX_CTL1, 8'h40);
    wb(1'b1, IDX_TSA, bq[0]);
    wb(1'b1, IDX_CTL1, 8'hC0);
    for (int i = 1; i < bq.size(); i++) begin
      poll(F_TX);
      wb(1'b1, IDX_DB, bq[i]);
      wb(1'b1, IDX_CTL1, (i == bq.size() - 1) ? 8'hD0 : 8'hC0);
    end
    poll(F_STOP);
    foreach (bq[i])
      chk("byte", bq[i], i_twmsp_slave_model.got.pop_front());
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Clock-high spacing never beats the fast rate
  always @(posedge scl) begin
    // First rise is the line leaving unknown at reset, not a bit
    if (t_last > 0.0)
      chk("bit_time", 8'h01, {7'h0, $realtime - t_last >= 2500.0});
    t_last = $realtime;
  end
  // Watchdog, about six times the expected run
  initial begin
    #2000000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Lines leaving unknown at power-up may look like a stop
    stops0 = i_twmsp_slave_model.stops;
    wb(1'b0, IDX_CTL1, 8'h00);
    chk("ctl1", CTL1_RST, q);
    wb(1'b0, IDX_CTL2, 8'h00);
    chk("ctl2", CTL2_RST, q);
    wb(1'b0, 6'h00, 8'h00);
    chk("unmapped", 8'h00, q);
    wb(1'b1, IDX_OWN_HI, 8'hFF);
    wb(1'b0, IDX_OWN_HI, 8'h00);
    chk("own_hi", 8'h03, q);
    $display("test registers done");
    bq = '{8'hA4, 8'($random(seed))};
    xfer(8'h05);
    $display("test seven_bit done");
    slow <= 1'b1;
    bq = '{{TEN_BIT_PREFIX, 3'h4}, 8'($random(seed)), 8'($random(seed))};
    xfer(8'h01);
    chk("stops", 8'h02, 8'(i_twmsp_slave_model.stops - stops0));
    $display("test ten_bit done");
    print_verdict;
  end
endmodule // twmsp_port_tb_top
